// ---- hdl/counter_control.sv ----
// Top: counter control word with low/unified and high counter halves
`timescale 1ns/100ps
module counter_control (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // Register port
  input  wire logic [ctrl_pkg::ADDR_W-1:0] addr,
  input  wire logic [31:0]               wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic [31:0]                    rdata,
  // Configuration and events
  input  wire logic                      single_wide_counter_mode,
  input  wire logic [31:0]               limit_value,
  input  wire logic                      low_stop_ev,
  input  wire logic                      low_halt_ev,
  input  wire logic                      low_start_ev,
  input  wire logic                      low_limit_ev,
  input  wire logic                      high_stop_ev,
  input  wire logic                      high_halt_ev,
  input  wire logic                      high_start_ev,
  input  wire logic                      high_limit_ev,
  // Counter state
  output logic [31:0]                    count,
  output logic                           low_running,
  output logic                           high_running,
  output logic                           events_enabled
);
  import ctrl_pkg::*;

  typedef struct packed {
    logic             low_down_unused;
    logic             low_stop;
    logic             low_halt;
    logic             low_updown;
    logic [PRE_W-1:0] low_pre;
    logic             high_stop;
    logic             high_halt;
    logic             high_updown;
    logic [PRE_W-1:0] high_pre;
    logic [31:0]      rdata;
    logic [31:0]      count;
    logic             low_run;
    logic             high_run;
    logic             ev_en;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  half_if     lo ();
  half_if     hi ();
  logic       hit;
  logic       low_clr;
  logic       high_clr;
  logic       low_go;
  logic       high_go;
  logic [31:0] ctrl_word;

  // Low half also carries the unified counter's lower bits
  half_counter u_low (
    .clk    (clk),
    .resetn (resetn),
    .hf     (lo)
  );

  // High half; in unified mode it is a carry extension of the low half
  half_counter u_high (
    .clk    (clk),
    .resetn (resetn),
    .hf     (hi)
  );

  assign hit      = (addr == CTRL_OFFSET);
  assign low_go   = !s_q.low_stop && !s_q.low_halt;
  assign high_go  = single_wide_counter_mode ? low_go : (!s_q.high_stop && !s_q.high_halt);

  // Clear strobes are write-only pulses; only accepted while that counter is idle
  assign low_clr  = wr && hit && wdata[LOW_CLEAR_BIT] && !low_go;
  assign high_clr = wr && hit && (single_wide_counter_mode ? (wdata[LOW_CLEAR_BIT] && !low_go)
                                                           : (wdata[HIGH_CLEAR_BIT] && !high_go));

  // Half control wiring
  always_comb begin
    lo.run       = low_go;
    lo.clear     = low_clr;
    lo.updown    = s_q.low_updown;
    lo.pre       = s_q.low_pre;
    lo.limit     = single_wide_counter_mode ? 16'hffff : limit_value[15:0];
    lo.carry_in  = 1'b1;
    lo.ext_limit = low_limit_ev && !s_q.low_halt;
    hi.run       = high_go;
    hi.clear     = high_clr;
    hi.updown    = single_wide_counter_mode ? s_q.low_updown : s_q.high_updown;
    hi.pre       = single_wide_counter_mode ? 8'h00 : s_q.high_pre;
    hi.limit     = limit_value[31:16];
    // Unified mode: high half steps when low half steps at all ones while counting up, no prescale of its own
    hi.carry_in  = single_wide_counter_mode ? lo.at_top : 1'b1;
    hi.ext_limit = high_limit_ev && !s_q.high_halt;
  end

  // Readback word; clear bits and reserved ranges read zero
  always_comb begin
    ctrl_word                                        = 32'h0000_0000;
    ctrl_word[0]                                     = lo.down;
    ctrl_word[1]                                     = s_q.low_stop;
    ctrl_word[2]                                     = s_q.low_halt;
    ctrl_word[LOW_UPDOWN_BIT]                        = s_q.low_updown;
    ctrl_word[LOW_PRE_LSB +: PRE_W]                  = s_q.low_pre;
    ctrl_word[HIGH_DOWN_BIT]                         = hi.down;
    ctrl_word[HIGH_STOP_BIT]                         = s_q.high_stop;
    ctrl_word[HIGH_HALT_BIT]                         = s_q.high_halt;
    ctrl_word[HIGH_UPDOWN_BIT]                       = s_q.high_updown;
    ctrl_word[HIGH_PRE_LSB +: PRE_W]                 = s_q.high_pre;
  end

  // Next-state of control bits
  always_comb begin
    s_d = s_q;
    // Events: start clears stop, stop and halt set; none while halted
    if (!s_q.low_halt) begin
      if (low_start_ev) s_d.low_stop = 1'b0;
      if (low_stop_ev)  s_d.low_stop = 1'b1;
      if (low_halt_ev)  s_d.low_halt = 1'b1;
    end
    if (!s_q.high_halt) begin
      if (high_start_ev) s_d.high_stop = 1'b0;
      if (high_stop_ev)  s_d.high_stop = 1'b1;
      if (high_halt_ev)  s_d.high_halt = 1'b1;
    end
    // Software write: stop/halt always, others only while idle
    if (wr && hit) begin
      s_d.low_stop  = wdata[1];
      s_d.low_halt  = wdata[2];
      s_d.high_stop = wdata[HIGH_STOP_BIT];
      s_d.high_halt = wdata[HIGH_HALT_BIT];
      if (!low_go) begin
        s_d.low_updown = wdata[LOW_UPDOWN_BIT];
        s_d.low_pre    = wdata[LOW_PRE_LSB +: PRE_W];
      end
      if (!single_wide_counter_mode && !high_go) begin
        s_d.high_updown = wdata[HIGH_UPDOWN_BIT];
        s_d.high_pre    = wdata[HIGH_PRE_LSB +: PRE_W];
      end
    end
    // Halt forces stop clear; halt rising by event or write
    if (s_d.low_halt)  s_d.low_stop  = 1'b0;
    if (s_d.high_halt) s_d.high_stop = 1'b0;
    // Read data valid only in the cycle after the strobe
    s_d.rdata    = (rd && hit) ? ctrl_word : 32'h0000_0000;
    s_d.count    = {hi.count, lo.count};
    s_d.low_run  = low_go;
    s_d.high_run = high_go;
    s_d.ev_en    = !s_q.low_halt || (!single_wide_counter_mode && !s_q.high_halt);
    s_d.low_down_unused = 1'b0;
  end

  // Reset forces both halts
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q           <= '0;
      s_q.low_halt  <= HALT_RESET;
      s_q.high_halt <= HALT_RESET;
      s_q.low_pre   <= PRE_RESET;
      s_q.high_pre  <= PRE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata          = s_q.rdata;
  assign count          = s_q.count;
  assign low_running    = s_q.low_run;
  assign high_running   = s_q.high_run;
  assign events_enabled = s_q.ev_en;
endmodule : counter_control

// ---- hdl/ctrl_pkg.sv ----
// Package: register map, field positions and reset values of the counter control word
package ctrl_pkg;
  // Register bus
  localparam int          ADDR_W          = 32;
  localparam logic [31:0] CTRL_OFFSET     = 32'h50004004;
  // Low or unified half
  localparam int          LOW_CLEAR_BIT   = 3;
  localparam int          LOW_UPDOWN_BIT  = 4;
  localparam int          LOW_PRE_LSB     = 5;
  // High half; field and counter widths of both halves
  localparam int          HIGH_DOWN_BIT   = 16;
  localparam int          HIGH_STOP_BIT   = 17;
  localparam int          HIGH_HALT_BIT   = 18;
  localparam int          HIGH_CLEAR_BIT  = 19;
  localparam int          HIGH_UPDOWN_BIT = 20;
  localparam int          HIGH_PRE_LSB    = 21;
  localparam int          PRE_W           = 8;
  localparam int          CNT_W           = 16;
  // Reset values
  localparam logic [7:0]  PRE_RESET       = 8'h00;
  localparam logic        HALT_RESET      = 1'b1;
  // State register of one counter half: count, down flag and prescale count
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             down;
    logic [PRE_W-1:0] pre_cnt;
  } half_state_t;
endpackage : ctrl_pkg

// ---- hdl/half_counter.sv ----
// One 16-bit counter half with prescaler and direction control
`timescale 1ns/100ps
module half_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control and status
  half_if.cnt      hf
);
  import ctrl_pkg::*;

  half_state_t s_q;
  half_state_t s_d;
  logic        step;
  logic        lim;

  // Prescale tick every pre+1 clocks, and limit at match, all ones or external event
  always_comb begin
    s_d  = s_q;
    step = hf.run && (s_q.pre_cnt == hf.pre) && hf.carry_in;
    lim  = (s_q.count == hf.limit) || (&s_q.count) || hf.ext_limit;
    if (hf.clear) begin
      s_d.count   = '0;
      s_d.down    = 1'b0;
      s_d.pre_cnt = '0;
    end else if (hf.run && hf.carry_in) begin
      s_d.pre_cnt = (s_q.pre_cnt == hf.pre) ? '0 : s_q.pre_cnt + 8'h01;
      if (step) begin
        if (!s_q.down) begin
          if (lim && hf.updown) begin
            s_d.down  = 1'b1;
            s_d.count = s_q.count - 16'h0001;
          end else if (lim) begin
            s_d.count = '0;
          end else begin
            s_d.count = s_q.count + 16'h0001;
          end
        end else if (lim || s_q.count == 16'h0001 || s_q.count == 16'h0000) begin
          s_d.down  = 1'b0;
          s_d.count = (s_q.count == 16'h0000) ? 16'h0001 : s_q.count - 16'h0001;
        end else begin
          s_d.count = s_q.count - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hf.count  = s_q.count;
  assign hf.down   = s_q.down;
  assign hf.at_top = step && !s_q.down && (&s_q.count);
  assign hf.tick   = step;
endmodule : half_counter

// ---- hdl/half_if.sv ----
// Interface: control and status of one counter half
`timescale 1ns/100ps
interface half_if;
  import ctrl_pkg::*;
  logic             run;
  logic             clear;
  logic             updown;
  logic [PRE_W-1:0] pre;
  logic [CNT_W-1:0] limit;
  logic             carry_in;
  logic             ext_limit;
  logic [CNT_W-1:0] count;
  logic             down;
  logic             at_top;
  logic             tick;
  modport ctl (output run, output clear, output updown, output pre, output limit, output carry_in,
               output ext_limit, input count, input down, input at_top, input tick);
  modport cnt (input run, input clear, input updown, input pre, input limit, input carry_in,
               input ext_limit, output count, output down, output at_top, output tick);
endinterface : half_if

// ---- tb/counter_control_monitor.sv ----
// Checker for the counter control word ports
`timescale 1ns/100ps
module counter_control_monitor (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        resetn,
  // Register port
  input wire logic [ctrl_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0]                 wdata,
  input wire logic                        wr,
  input wire logic                        rd,
  input wire logic [31:0]                 rdata,
  // Counter state
  input wire logic [31:0]                 count,
  input wire logic                        high_running,
  input wire logic                        events_enabled
);
  import ctrl_pkg::*;
  default clocking mc @(posedge clk); endclocking
  default disable iff (!resetn);
  logic hit;
  // Write that hits the control word
  assign hit = wr && addr == CTRL_OFFSET;
  // Write that sets the high halt bit
  sequence halt_wr;
    hit && wdata[HIGH_HALT_BIT];
  endsequence
  chk_idle_rdata: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("rdata without read");
  chk_clear_read: assert property ($past(rd) |-> !rdata[LOW_CLEAR_BIT] && !rdata[HIGH_CLEAR_BIT])
    else $error("clear bit reads one");
  chk_reserved_zero: assert property (rdata[15:13] == 3'h0 && rdata[31:29] == 3'h0)
    else $error("reserved bits set");
  chk_halt_nostop: assert property ($past(rd) |-> !(rdata[HIGH_HALT_BIT] && rdata[HIGH_STOP_BIT]))
    else $error("stop with halt");
  chk_halt_freeze: assert property (halt_wr |-> ##2 !high_running)
    else $error("high runs while halted");
  chk_stop_write: assert property (hit && wdata[HIGH_STOP_BIT] && !wdata[HIGH_HALT_BIT] |-> ##[1:2] !high_running)
    else $error("high runs after stop");
  chk_halt_sticky: assert property (!events_enabled && !wr && !$past(wr) |=> !events_enabled)
    else $error("halt left without write");
  chk_both_frozen: assert property (!events_enabled && !wr && !$past(wr) && !$past(wr, 2) |-> $stable(count))
    else $error("count moved while halted");
endmodule : counter_control_monitor

// ---- tb/counter_control_test.sv ----
// Testbench: register port, halt and stop handling, prescaled counting
`timescale 1ns/100ps
module counter_control_test;
  import ctrl_pkg::*;
  logic              clk, resetn, wr, rd, uni;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wdata, rdata, count, got;
  logic [7:0]        ev;
  int                n_fail, samples_checked;
  // Events travel as one byte of one-cycle pulses
  counter_control u_counter_control (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .single_wide_counter_mode(uni), .limit_value(32'h0004_0004),
    .low_stop_ev(ev[0]), .low_halt_ev(ev[1]), .low_start_ev(ev[2]), .low_limit_ev(ev[3]),
    .high_stop_ev(ev[4]), .high_halt_ev(ev[5]), .high_start_ev(ev[6]), .high_limit_ev(ev[7]),
    .count(count), .low_running(), .high_running(), .events_enabled()
  );
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic wr_reg(input logic [31:0] d);
    @(posedge clk);
    addr  <= CTRL_OFFSET;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [31:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    got = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [31:0] e);
    rd_reg(CTRL_OFFSET);
    check(got, e);
  endtask : rd_chk
  task automatic pulse(input logic [7:0] p);
    @(posedge clk);
    ev <= p;
    @(posedge clk);
    ev <= 8'h00;
  endtask : pulse
  // Reset value, unmapped read, write of all ones but the down bits 0 and 16 while halted
  task automatic t_fields;
    rd_chk(32'h0004_0004);
    rd_reg(32'h5000_4000);
    check(got, 32'h0);
    wr_reg(32'hfffe_fffe);
    rd_chk(32'h1ff4_1ff4);
    wr_reg(32'h0002_0002);
    rd_chk(32'h0002_0002);
  endtask : t_fields
  // One half: clear, step period, wrap or turn at limit, down flag
  task automatic t_count(input int sh, input logic ud);
    int          n;
    logic [15:0] p;
    wr_reg(32'h0004_0004);
    wr_reg(((32'h4c | {ud, 4'h0}) << sh) | (32'h4 << (16 - sh)));
    repeat (2) @(negedge clk);
    check(32'(16'(count >> sh)), 32'h0);
    wr_reg(((32'h40 | {ud, 4'h0}) << sh) | (32'h4 << (16 - sh)));
    for (int k = 0; k < 2; k++) begin
      p = 16'(count >> sh);
      for (n = 0; n < 40 && p === 16'(count >> sh); n++) @(negedge clk);
    end
    check(32'(n), 32'h3);
    for (n = 0; n < 40 && 16'(count >> sh) !== 16'h4; n++) @(negedge clk);
    for (n = 0; n < 40 && 16'(count >> sh) === 16'h4; n++) @(negedge clk);
    check(32'(16'(count >> sh)), ud ? 32'h3 : 32'h0);
    rd_reg(CTRL_OFFSET);
    check(32'(got[sh]), 32'(ud));
  endtask : t_count
  // Stop, start and halt events on one half while the other runs
  task automatic t_events;
    for (int h = 0; h < 2; h++) begin
      wr_reg(32'h0004_0004);
      wr_reg(32'h0008_0008);
      wr_reg(32'h1ff0_1ff0);
      pulse(8'h8 << (4 * h));
      rd_chk(32'h0);
      pulse(8'h1 << (4 * h));
      rd_chk(32'h2 << (16 * h));
      pulse(8'h4 << (4 * h));
      rd_chk(32'h0);
      pulse(8'h2 << (4 * h));
      rd_chk(32'h4 << (16 * h));
      pulse(8'h4 << (4 * h));
      rd_chk(32'h4 << (16 * h));
    end
  endtask : t_events
  // Unified mode: low limit ignored, high half only takes carries
  task automatic t_unified;
    uni <= 1'b1;
    wr_reg(32'h0004_0004);
    wr_reg(32'h0000_0008);
    repeat (12) @(negedge clk);
    check(32'(count[15:0] > 16'h4), 32'h1);
    check(32'(count[31:16]), 32'h0);
    wr_reg(32'h0004_0004);
    uni <= 1'b0;
  endtask : t_unified
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  // Clock at 10 MHz
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  // Main sequence
  initial begin
    {resetn, wr, rd, uni, ev, addr, wdata} = 76'h0;
    n_fail = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_fields();
    for (int s = 0; s < 32; s += 16) begin
      t_count(s, 1'b0);
      t_count(s, 1'b1);
    end
    t_events();
    t_unified();
    finish_test();
  end
endmodule : counter_control_test
bind counter_control counter_control_monitor u_counter_control_monitor (
  .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .count(count), .high_running(high_running), .events_enabled(events_enabled)
);
